//--- hw/mcp_pkg.sv
// Behaviour
// - Save command copies parameters to non-volatile image.
// - Unsaved changes vanish; power-up reloads stored image.
// - Exit command leaves command mode at once.
// - Receive indicator: 0 normal, 1 high, 2 low.
// - Output two: CTS, enable low, high, enable high, low.
// - Read-only signal strength byte of last packet.
// - Sixteen-bit destination address, default zero.
// - Sixteen-bit address mask, default all ones.
// - Force-wake flags preamble before next transmission.
// - Channel 0..6 hopping, 0..0x18 single frequency.
// - Restore returns settable parameters to factory values.
// - Serial number read as upper and lower halves.
// - Hardware version read-only; writes rejected.
// - Firmware version readable, two bytes.
// - Command without argument replies current value.
// - Reply OK or ERROR, each ending in CR.
// - Arguments hexadecimal; letters case-insensitive.
// - Inactivity timeout leaves command mode automatically.
package mcp_pkg;
   // Factory values of the settable parameters
   localparam logic [7:0] RXSEL_RST = 8'h00;
   localparam logic [7:0] OUT2SEL_RST = 8'h00;
   localparam logic [7:0] CHAN_RST = 8'h00;
   localparam logic [15:0] DEST_RST = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'hffff;
   // Image layout: {rx select, out2 select, channel, dest, mask}
   localparam int IMG_W = 56;
   localparam logic [IMG_W-1:0] FACTORY_IMG =
      {RXSEL_RST, OUT2SEL_RST, CHAN_RST, DEST_RST, MASK_RST};
   // Setting limits
   localparam logic [15:0] RXSEL_MAX = 16'h0002;
   localparam logic [15:0] OUT2SEL_MAX = 16'h0004;
   localparam logic [15:0] CHAN_HOP_MAX = 16'h0006;
   localparam logic [15:0] CHAN_SF_MAX = 16'h0018;
   // Receive indicator selections
   localparam logic [7:0] RXSEL_HIGH = 8'h01;
   localparam logic [7:0] RXSEL_LOW = 8'h02;
   // Output two selections
   localparam logic [7:0] O2_ENLOW = 8'h01;
   localparam logic [7:0] O2_HIGH = 8'h02;
   localparam logic [7:0] O2_ENHIGH = 8'h03;
   localparam logic [7:0] O2_LOW = 8'h04;
   // Characters
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_COMMA = 8'h2c;
   localparam logic [7:0] CH_A = 8'h41;
   localparam logic [7:0] CH_T = 8'h54;
   // Command letter pairs, upper case ASCII
   localparam logic [15:0] C_NONE = 16'h0000;
   localparam logic [15:0] C_RXSEL = 16'h4344;
   localparam logic [15:0] C_LEAVE = 16'h434e;
   localparam logic [15:0] C_OUT2 = 16'h4353;
   localparam logic [15:0] C_RSSI = 16'h4442;
   localparam logic [15:0] C_DEST = 16'h4454;
   localparam logic [15:0] C_WAKE = 16'h4648;
   localparam logic [15:0] C_CHAN = 16'h4850;
   localparam logic [15:0] C_HWVER = 16'h4856;
   localparam logic [15:0] C_MASK = 16'h4d4b;
   localparam logic [15:0] C_RESTORE = 16'h5245;
   localparam logic [15:0] C_SNUP = 16'h5348;
   localparam logic [15:0] C_SNLO = 16'h534c;
   localparam logic [15:0] C_FWVER = 16'h5652;
   localparam logic [15:0] C_SAVE = 16'h5752;
   // Inactivity tick: timeout setting counts 100 ms units
   localparam int TICK_MS = 100;
   localparam int CLK_KHZ = 50000;
   localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
   localparam int TICK_W = 23;
   // Parser states
   typedef enum logic [2:0] {
      ST_IDLE, ST_PFX_A, ST_PFX_T, ST_CMD1, ST_CMD2, ST_ARG, ST_REPLY
   } mcp_state_t;
   // Reply kinds
   typedef enum logic [1:0] {RK_OK, RK_ERR, RK_VAL} mcp_reply_t;
endpackage : mcp_pkg

//--- hw/mcp_top.sv
`timescale 1ns/1ps
module mcp_top #(
   parameter int TICK_CYCLES = mcp_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // Command mode entry from the guard-time logic
   input wire logic CMD_ENTER,
   input wire logic [15:0] IDLE_TIMEOUT,
   output logic CMD_MODE,
   // Received serial characters
   input wire logic [7:0] RX_DATA,
   input wire logic RX_VALID,
   output logic RX_READY,
   // Reply characters
   output logic [7:0] TX_DATA,
   output logic TX_VALID,
   input wire logic TX_READY,
   // Non-volatile image
   input wire logic [55:0] NV_IMAGE_IN,
   output logic [55:0] NV_IMAGE_OUT,
   output logic NV_WRITE,
   // Diagnostics
   input wire logic [7:0] RSSI,
   input wire logic [15:0] HW_VERSION,
   input wire logic [15:0] FW_VERSION,
   input wire logic [31:0] SERIAL_NUMBER,
   input wire logic HOP_MODE,
   // Radio and output line control
   input wire logic RX_ACTIVITY,
   input wire logic CTS_IN,
   input wire logic TX_DRIVE,
   input wire logic WAKE_SENT,
   output logic [15:0] DEST_ADDR,
   output logic [15:0] ADDR_MASK,
   output logic [7:0] CHANNEL,
   output logic FORCE_WAKE,
   output logic RX_IND,
   output logic OUT2
);
   // All state of the block
   typedef struct packed {
      mcp_pkg::mcp_state_t st;
      logic mode;
      logic [7:0] l1;
      logic [7:0] l2;
      logic [15:0] arg;
      logic [2:0] ndig;
      logic has_arg;
      logic err;
      mcp_pkg::mcp_reply_t rk;
      logic [15:0] rv;
      logic [2:0] rlen;
      logic [2:0] ridx;
      mcp_pkg::mcp_state_t after;
      logic [7:0] rxsel;
      logic [7:0] o2sel;
      logic [7:0] chan;
      logic [15:0] dest;
      logic [15:0] mask;
      logic wake;
      logic nvw;
      logic load;
      logic [55:0] nvo;
      logic [7:0] txd;
      logic txv;
      logic rxr;
      logic rxo;
      logic o2;
      logic [mcp_pkg::TICK_W-1:0] tick;
      logic [15:0] idle;
   } mcp_reg_t;

   mcp_reg_t r_r;
   mcp_reg_t r_nxt;

   // Fold letters to upper case
   function automatic logic [7:0] mcp_upper(input logic [7:0] c);
      mcp_upper = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
   endfunction : mcp_upper

   // Hex digit value, bit 4 set when the character is a hex digit
   function automatic logic [4:0] mcp_hex(input logic [7:0] c);
      logic [7:0] u;
      u = mcp_upper(c);
      if (u >= 8'h30 && u <= 8'h39) begin
         mcp_hex = {1'b1, 4'(u - 8'h30)};
      end else if (u >= 8'h41 && u <= 8'h46) begin
         mcp_hex = {1'b1, 4'(u - 8'h37)};
      end else begin
         mcp_hex = 5'h00;
      end
   endfunction : mcp_hex

   // Letters and digits; anything else but CR or comma acts as optional space, except between the two letters
   function automatic logic mcp_alnum(input logic [7:0] c);
      logic [7:0] u;
      u = mcp_upper(c);
      mcp_alnum = (u >= 8'h30 && u <= 8'h39) || (u >= 8'h41 && u <= 8'h5a);
   endfunction : mcp_alnum

   // Character idx of a reply; the last one is always CR
   function automatic logic [7:0] mcp_char(input mcp_pkg::mcp_reply_t k,
         input logic [15:0] v, input logic [2:0] len, input logic [2:0] idx);
      logic [3:0] nib;
      nib = 4'(v >> {(len - 3'd2 - idx), 2'b00});
      if (idx == len - 3'd1) begin
         mcp_char = mcp_pkg::CH_CR;
      end else if (k == mcp_pkg::RK_OK) begin
         mcp_char = (idx == 3'd0) ? 8'h4f : 8'h4b;
      end else if (k == mcp_pkg::RK_ERR) begin
         case (idx)
            3'd0: mcp_char = 8'h45;
            3'd3: mcp_char = 8'h4f;
            default: mcp_char = 8'h52;
         endcase
      end else begin
         // Values are returned as upper-case hex
         mcp_char = (nib < 4'ha) ? 8'h30 + 8'(nib) : 8'h37 + 8'(nib);
      end
   endfunction : mcp_char

   // Next-state logic
   always_comb begin
      logic take;
      logic term;
      logic exec;
      logic leave;
      logic [7:0] u;
      logic [4:0] hx;
      logic [15:0] code;
      logic [15:0] lim;
      take = RX_VALID && r_r.rxr;
      u = mcp_upper(RX_DATA);
      hx = mcp_hex(RX_DATA);
      term = (RX_DATA == mcp_pkg::CH_CR) || (RX_DATA == mcp_pkg::CH_COMMA);
      exec = 1'b0;
      leave = 1'b0;
      code = {r_r.l1, r_r.l2};
      lim = 16'h0000;
      r_nxt = r_r;
      r_nxt.nvw = 1'b0;
      // Stored image is taken once after reset; unsaved edits are lost
      if (r_r.load) begin
         r_nxt.load = 1'b0;
         {r_nxt.rxsel, r_nxt.o2sel, r_nxt.chan, r_nxt.dest, r_nxt.mask} =
            NV_IMAGE_IN;
      end
      // Wake request drops once the preamble has gone out
      if (WAKE_SENT) begin
         r_nxt.wake = 1'b0;
      end
      // Output line selection, registered so the pins come from flops
      case (r_r.rxsel)
         mcp_pkg::RXSEL_HIGH: r_nxt.rxo = 1'b1;
         mcp_pkg::RXSEL_LOW: r_nxt.rxo = 1'b0;
         default: r_nxt.rxo = RX_ACTIVITY;
      endcase
      case (r_r.o2sel)
         mcp_pkg::O2_ENLOW: r_nxt.o2 = ~TX_DRIVE;
         mcp_pkg::O2_HIGH: r_nxt.o2 = 1'b1;
         mcp_pkg::O2_ENHIGH: r_nxt.o2 = TX_DRIVE;
         mcp_pkg::O2_LOW: r_nxt.o2 = 1'b0;
         default: r_nxt.o2 = CTS_IN;
      endcase
      // Parser; the host must have entered command mode first
      case (r_r.st)
         mcp_pkg::ST_IDLE: begin
            if (CMD_ENTER) begin
               r_nxt.st = mcp_pkg::ST_PFX_A;
               r_nxt.mode = 1'b1;
               r_nxt.tick = '0;
               r_nxt.idle = 16'h0000;
            end
         end
         mcp_pkg::ST_PFX_A: begin
            if (take && u == mcp_pkg::CH_A) begin
               r_nxt.st = mcp_pkg::ST_PFX_T;
            end
         end
         mcp_pkg::ST_PFX_T: begin
            if (take) begin
               r_nxt.st = (u == mcp_pkg::CH_T) ? mcp_pkg::ST_CMD1
                                               : mcp_pkg::ST_PFX_A;
            end
         end
         mcp_pkg::ST_CMD1, mcp_pkg::ST_CMD2, mcp_pkg::ST_ARG: begin
            if (take) begin
               if (term) begin
                  exec = 1'b1;
               end else if (r_r.st == mcp_pkg::ST_ARG && hx[4]) begin
                  // Hex argument, at most four digits
                  r_nxt.arg = {r_r.arg[11:0], hx[3:0]};
                  r_nxt.has_arg = 1'b1;
                  r_nxt.ndig = r_r.ndig + 3'd1;
                  if (r_r.ndig == 3'd4) begin
                     r_nxt.err = 1'b1;
                  end
               end else if (!mcp_alnum(RX_DATA)) begin
                  // Optional space between letters and argument
                  if (r_r.st == mcp_pkg::ST_CMD2) begin
                     r_nxt.err = 1'b1;
                  end
               end else if (r_r.st == mcp_pkg::ST_CMD1) begin
                  r_nxt.l1 = u;
                  r_nxt.st = mcp_pkg::ST_CMD2;
               end else if (r_r.st == mcp_pkg::ST_CMD2) begin
                  r_nxt.l2 = u;
                  r_nxt.st = mcp_pkg::ST_ARG;
               end else begin
                  r_nxt.err = 1'b1;
               end
            end
         end
         mcp_pkg::ST_REPLY: begin
            if (r_r.txv && TX_READY) begin
               if (r_r.ridx == r_r.rlen - 3'd1) begin
                  r_nxt.txv = 1'b0;
                  r_nxt.st = r_r.after;
               end else begin
                  r_nxt.ridx = r_r.ridx + 3'd1;
                  r_nxt.txd = mcp_char(r_r.rk, r_r.rv, r_r.rlen,
                                       r_r.ridx + 3'd1);
               end
            end
         end
         default: r_nxt.st = mcp_pkg::ST_IDLE;
      endcase
      // Execute one command at its comma or CR
      if (exec) begin
         r_nxt.rk = mcp_pkg::RK_OK;
         r_nxt.rv = 16'h0000;
         r_nxt.rlen = 3'd3;
         if (r_r.err || (r_r.st == mcp_pkg::ST_CMD2)) begin
            r_nxt.rk = mcp_pkg::RK_ERR;
         end else if (!r_r.has_arg &&
               (code == mcp_pkg::C_RXSEL || code == mcp_pkg::C_OUT2 ||
                code == mcp_pkg::C_CHAN || code == mcp_pkg::C_RSSI)) begin
            // Query of a one-byte value
            r_nxt.rk = mcp_pkg::RK_VAL;
            r_nxt.rlen = 3'd3;
            if (code == mcp_pkg::C_RXSEL) begin
               r_nxt.rv = {8'h00, r_r.rxsel};
            end else if (code == mcp_pkg::C_OUT2) begin
               r_nxt.rv = {8'h00, r_r.o2sel};
            end else if (code == mcp_pkg::C_CHAN) begin
               r_nxt.rv = {8'h00, r_r.chan};
            end else begin
               r_nxt.rv = {8'h00, RSSI};
            end
         end else if (!r_r.has_arg &&
               (code == mcp_pkg::C_DEST || code == mcp_pkg::C_MASK ||
                code == mcp_pkg::C_HWVER || code == mcp_pkg::C_FWVER ||
                code == mcp_pkg::C_SNUP || code == mcp_pkg::C_SNLO)) begin
            // Query of a two-byte value
            r_nxt.rk = mcp_pkg::RK_VAL;
            r_nxt.rlen = 3'd5;
            if (code == mcp_pkg::C_DEST) begin
               r_nxt.rv = r_r.dest;
            end else if (code == mcp_pkg::C_MASK) begin
               r_nxt.rv = r_r.mask;
            end else if (code == mcp_pkg::C_HWVER) begin
               r_nxt.rv = HW_VERSION;
            end else if (code == mcp_pkg::C_FWVER) begin
               r_nxt.rv = FW_VERSION;
            end else if (code == mcp_pkg::C_SNUP) begin
               r_nxt.rv = SERIAL_NUMBER[31:16];
            end else begin
               r_nxt.rv = SERIAL_NUMBER[15:0];
            end
         end else if (code == mcp_pkg::C_RXSEL) begin
            lim = mcp_pkg::RXSEL_MAX;
            if (r_r.arg > lim) r_nxt.rk = mcp_pkg::RK_ERR;
            else r_nxt.rxsel = r_r.arg[7:0];
         end else if (code == mcp_pkg::C_OUT2) begin
            lim = mcp_pkg::OUT2SEL_MAX;
            if (r_r.arg > lim) r_nxt.rk = mcp_pkg::RK_ERR;
            else r_nxt.o2sel = r_r.arg[7:0];
         end else if (code == mcp_pkg::C_CHAN) begin
            lim = HOP_MODE ? mcp_pkg::CHAN_HOP_MAX : mcp_pkg::CHAN_SF_MAX;
            if (r_r.arg > lim) r_nxt.rk = mcp_pkg::RK_ERR;
            else r_nxt.chan = r_r.arg[7:0];
         end else if (code == mcp_pkg::C_DEST) begin
            r_nxt.dest = r_r.arg;
         end else if (code == mcp_pkg::C_MASK) begin
            r_nxt.mask = r_r.arg;
         end else if (r_r.has_arg) begin
            // Read-only values and actions take no argument
            r_nxt.rk = mcp_pkg::RK_ERR;
         end else if (code == mcp_pkg::C_LEAVE) begin
            leave = 1'b1;
         end else if (code == mcp_pkg::C_WAKE) begin
            r_nxt.wake = 1'b1;
         end else if (code == mcp_pkg::C_RESTORE) begin
            {r_nxt.rxsel, r_nxt.o2sel, r_nxt.chan, r_nxt.dest,
             r_nxt.mask} = mcp_pkg::FACTORY_IMG;
         end else if (code == mcp_pkg::C_SAVE) begin
            r_nxt.nvo = {r_r.rxsel, r_r.o2sel, r_r.chan, r_r.dest,
                         r_r.mask};
            r_nxt.nvw = 1'b1;
         end else if (code != mcp_pkg::C_NONE) begin
            r_nxt.rk = mcp_pkg::RK_ERR;
         end
         if (r_nxt.rk == mcp_pkg::RK_ERR) begin
            r_nxt.rlen = 3'd6;
         end else begin
            // A valid command restarts the inactivity timer
            r_nxt.tick = '0;
            r_nxt.idle = 16'h0000;
         end
         r_nxt.l1 = 8'h00;
         r_nxt.l2 = 8'h00;
         r_nxt.arg = 16'h0000;
         r_nxt.ndig = 3'd0;
         r_nxt.has_arg = 1'b0;
         r_nxt.err = 1'b0;
         r_nxt.ridx = 3'd0;
         r_nxt.txv = 1'b1;
         r_nxt.txd = mcp_char(r_nxt.rk, r_nxt.rv, r_nxt.rlen, 3'd0);
         r_nxt.st = mcp_pkg::ST_REPLY;
         if (leave) begin
            // Mode ends now; the OK still goes out before idling
            r_nxt.mode = 1'b0;
            r_nxt.after = mcp_pkg::ST_IDLE;
         end else if (RX_DATA == mcp_pkg::CH_COMMA) begin
            r_nxt.after = mcp_pkg::ST_CMD1;
         end else begin
            r_nxt.after = mcp_pkg::ST_PFX_A;
         end
      end
      // Inactivity timer in 100 ms ticks; it aborts a reply too, except the OK of an exit
      if (r_r.mode && !exec) begin
         r_nxt.tick = r_r.tick + 1'b1;
         if (r_r.tick == mcp_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            r_nxt.tick = '0;
            r_nxt.idle = r_r.idle + 16'h0001;
            if (r_nxt.idle >= IDLE_TIMEOUT) begin
               r_nxt.mode = 1'b0;
               r_nxt.st = mcp_pkg::ST_IDLE;
               r_nxt.txv = 1'b0;
            end
         end
      end
      // Characters are accepted only while parsing
      r_nxt.rxr = r_nxt.st inside {mcp_pkg::ST_PFX_A, mcp_pkg::ST_PFX_T,
         mcp_pkg::ST_CMD1, mcp_pkg::ST_CMD2, mcp_pkg::ST_ARG};
   end

   // State register; reset arms the load of the stored image
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         r_r <= '0;
         r_r.st <= mcp_pkg::ST_IDLE;
         r_r.rxsel <= mcp_pkg::RXSEL_RST;
         r_r.o2sel <= mcp_pkg::OUT2SEL_RST;
         r_r.chan <= mcp_pkg::CHAN_RST;
         r_r.dest <= mcp_pkg::DEST_RST;
         r_r.mask <= mcp_pkg::MASK_RST;
         r_r.load <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Ports straight from the state register
   assign CMD_MODE = r_r.mode;
   assign RX_READY = r_r.rxr;
   assign TX_DATA = r_r.txd;
   assign TX_VALID = r_r.txv;
   assign NV_IMAGE_OUT = r_r.nvo;
   assign NV_WRITE = r_r.nvw;
   assign DEST_ADDR = r_r.dest;
   assign ADDR_MASK = r_r.mask;
   assign CHANNEL = r_r.chan;
   assign FORCE_WAKE = r_r.wake;
   assign RX_IND = r_r.rxo;
   assign OUT2 = r_r.o2;
endmodule : mcp_top

//--- sim/mcp_host_model.sv
`timescale 1ns/1ps
// Host side: types command lines and drains reply characters
module mcp_host_model (
   // Clock
   input logic clock,
   // Characters toward the parser
   output logic [7:0] rx_data,
   output logic rx_valid,
   input logic rx_ready,
   // Reply characters back
   input logic [7:0] tx_data,
   input logic tx_valid,
   output logic tx_ready
);
   logic slow = 1'h0; // Slow sink, every other cycle
   logic [7:0] got[$]; // Reply characters not yet claimed

   // Idle lines
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'h0;
      tx_ready = 1'h1;
   end

   // Slow host halves its rate to test holding
   always @(negedge clock) begin
      tx_ready <= slow ? !tx_ready : 1'h1;
   end

   // Collect accepted characters
   always @(posedge clock) begin
      if (tx_valid && tx_ready) begin
         got.push_back(tx_data);
      end
   end

   // One line, each character held until taken
   task send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(negedge clock);
         rx_data = s[i];
         rx_valid = 1'h1;
         while (rx_ready !== 1'h1) @(negedge clock);
      end
      @(negedge clock);
      rx_valid = 1'h0;
      rx_data = ~rx_data; // Released line shows no stale character
   endtask : send

   // One whole reply; returns at a falling edge
   task reply(output string s);
      logic [7:0] c;
      s = "";
      do begin
         wait (got.size() > 0);
         c = got.pop_front();
         s = $sformatf("%s%c", s, c);
      end while (c != 8'h0d);
      @(negedge clock);
   endtask : reply
endmodule : mcp_host_model

//--- sim/mcp_top_monitor.sv
`timescale 1ns/1ps
// Port checks on the interpreter
module mcp_checker #(
   parameter int TICK_CYCLES = 10
) (
   // Clock and reset
   input logic CLOCK,
   input logic RSTN,
   // Mode control
   input logic CMD_ENTER,
   input logic [15:0] IDLE_TIMEOUT,
   input logic CMD_MODE,
   input logic RX_READY,
   // Replies
   input logic [7:0] TX_DATA,
   input logic TX_VALID,
   input logic TX_READY,
   // Settings and storage
   input logic [55:0] NV_IMAGE_OUT,
   input logic NV_WRITE,
   input logic WAKE_SENT,
   input logic FORCE_WAKE,
   input logic [15:0] DEST_ADDR,
   input logic [15:0] ADDR_MASK,
   input logic [7:0] CHANNEL
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   logic [31:0] quiet_r; // Quiet cycles in command mode
   logic [31:0] quiet_lim; // Tick phase unknown: one spare tick plus slack
   assign quiet_lim = (32'(IDLE_TIMEOUT) + 32'h1) * TICK_CYCLES + 32'h8;

   // Restart on entry, replies, outside the mode
   always_ff @(posedge CLOCK) begin
      if (!RSTN || !CMD_MODE || CMD_ENTER || TX_VALID) begin
         quiet_r <= 32'h0;
      end else begin
         quiet_r <= quiet_r + 32'h1;
      end
   end

   // Reply character accepted
   sequence s_took(logic [7:0] c);
      TX_VALID && TX_READY && TX_DATA == c;
   endsequence
   // Error tail: R then O
   sequence s_err_ro;
      s_took(8'h52) ##1 s_took(8'h4f);
   endsequence

   reset_values_a: assert property (
      disable iff (1'h0) !RSTN |=> !CMD_MODE && !TX_VALID && !NV_WRITE
      && DEST_ADDR == 16'h0000 && ADDR_MASK == 16'hffff)
      else $error("outputs not at reset values");
   reply_hold_a: assert property (
      TX_VALID && !TX_READY |=> (TX_VALID && $stable(TX_DATA)) || !CMD_MODE)
      else $error("reply character dropped");
   ready_gate_a: assert property (
      !CMD_MODE || TX_VALID |-> !RX_READY)
      else $error("characters accepted while barred");
   ok_tail_a: assert property (
      s_took(8'h4b) |=> TX_VALID && TX_DATA == 8'h0d)
      else $error("OK not closed by CR");
   err_tail_a: assert property (
      s_err_ro |=> TX_VALID && TX_DATA == 8'h52)
      else $error("error reply malformed");
   save_pulse_a: assert property (
      NV_WRITE |=> !NV_WRITE)
      else $error("save strobe too long");
   save_image_a: assert property (
      NV_WRITE |-> NV_IMAGE_OUT[39:0] == {CHANNEL, DEST_ADDR, ADDR_MASK})
      else $error("saved image wrong");
   wake_sticky_a: assert property (
      FORCE_WAKE && !WAKE_SENT |=> FORCE_WAKE)
      else $error("wake request lost");
   enter_mode_a: assert property (
      CMD_ENTER && !CMD_MODE && !TX_VALID |=> CMD_MODE && RX_READY)
      else $error("command mode not entered");
   idle_limit_a: assert property (
      CMD_MODE |-> quiet_r <= quiet_lim)
      else $error("command mode outlived timeout");
endmodule : mcp_checker

bind mcp_top mcp_checker #(.TICK_CYCLES(TICK_CYCLES)) u_mcp_checker (.*);

//--- sim/mcp_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench
module mcp_top_tb;
   logic clock, rstn, cmd_enter, cmd_mode, rx_ready, rx_valid, tx_valid;
   logic tx_ready, nv_write, hop_mode, rx_activity, cts_in, tx_drive;
   logic wake_sent, force_wake, rx_ind, out2;
   logic [7:0] rx_data, tx_data, rssi, channel;
   logic [15:0] idle_timeout, hw_version, fw_version, dest_addr, addr_mask;
   logic [31:0] serial_number;
   logic [55:0] nv_in, nv_out, nv_saved; // Stored image and last save
   int n_errors = 0;
   int checks_done = 0;

   // 50 MHz clock
   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end

   // Short tick keeps timeouts brief
   mcp_top #(.TICK_CYCLES(10)) u_mcp_top (
      .CLOCK(clock), .RSTN(rstn), .CMD_ENTER(cmd_enter),
      .IDLE_TIMEOUT(idle_timeout), .CMD_MODE(cmd_mode), .RX_DATA(rx_data),
      .RX_VALID(rx_valid), .RX_READY(rx_ready), .TX_DATA(tx_data),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .NV_IMAGE_IN(nv_in),
      .NV_IMAGE_OUT(nv_out), .NV_WRITE(nv_write), .RSSI(rssi),
      .HW_VERSION(hw_version), .FW_VERSION(fw_version),
      .SERIAL_NUMBER(serial_number), .HOP_MODE(hop_mode),
      .RX_ACTIVITY(rx_activity), .CTS_IN(cts_in), .TX_DRIVE(tx_drive),
      .WAKE_SENT(wake_sent), .DEST_ADDR(dest_addr), .ADDR_MASK(addr_mask),
      .CHANNEL(channel), .FORCE_WAKE(force_wake), .RX_IND(rx_ind),
      .OUT2(out2));
   mcp_host_model u_mcp_host_model (
      .clock(clock), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready));

   // Image the parser stores
   always @(posedge clock) begin
      if (nv_write) nv_saved <= nv_out;
   end

   // Value compare; an unknown matches only an unknown
   task chk(input logic [55:0] got, input logic [55:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Reply text as a value
   function automatic logic [55:0] pk(input string s);
      logic [55:0] v;
      v = 56'h0;
      for (int i = 0; i < s.len(); i++) v = {v[47:0], s[i]};
      return v;
   endfunction : pk

   // Expected second output
   function automatic logic o2(input int s, input logic c, input logic d);
      case (s)
         0: return c;
         1: return !d;
         2: return 1'h1;
         3: return d;
         default: return 1'h0;
      endcase
   endfunction : o2

   // Send a line, if any, and judge the next reply
   task cmd(input string s, input string exp);
      string r;
      if (s.len() > 0) u_mcp_host_model.send(s);
      u_mcp_host_model.reply(r);
      chk(pk(r), pk(exp));
   endtask : cmd

   // Entry pulse from guard logic
   task enter;
      @(negedge clock);
      cmd_enter = 1'h1;
      @(negedge clock);
      cmd_enter = 1'h0;
   endtask : enter

   // Power cycle with a given stored image
   task power_up(input logic [55:0] img);
      nv_in = img;
      rstn = 1'h0;
      repeat (16) @(negedge clock);
      rstn = 1'h1;
      repeat (3) @(negedge clock);
   endtask : power_up

   // Stored settings appear after power-up
   task t_reload;
      power_up(56'h01020512_3400f0);
      chk({out2, rx_ind, channel, dest_addr, addr_mask},
         {2'h3, 40'h05_1234_00f0});
   endtask : t_reload

   // Writes, queries, case and digit limits
   task t_set;
      enter();
      cmd("ATDT 1f\r", "OK\r");
      cmd("atdt\r", "001F\r");
      cmd("ATDT 12345\r", "ERROR\r");
      chk(dest_addr, 16'h001f);
      cmd("ATMK\r", "00F0\r");
      cmd("aTmK a0D\r", "OK\r");
      chk(addr_mask, 16'h0a0d);
   endtask : t_set

   // Read-only values, refusals, slow host
   task t_ro;
      string q[8] = '{"ATDB\r", "ATSH\r", "ATSL\r", "ATVR\r", "ATHV\r",
         "ATHV 1\r", "ATZZ\r", "ATDB 5\r"};
      string a[8] = '{"6A\r", "89AB\r", "CDEF\r", "1B07\r", "3C5A\r",
         "ERROR\r", "ERROR\r", "ERROR\r"};
      u_mcp_host_model.slow = 1'h1;
      for (int i = 0; i < 8; i++) cmd(q[i], a[i]);
      u_mcp_host_model.slow = 1'h0;
   endtask : t_ro

   // Each line selection; past the top refused
   task t_lines;
      int cs, cd;
      for (int s = 0; s < 6; s++) begin
         cs = (s > 4) ? 4 : s;
         cd = (s > 2) ? 2 : s;
         cmd($sformatf("ATCS %0d\r", s), s < 5 ? "OK\r" : "ERROR\r");
         cmd($sformatf("ATCD %0d\r", s), s < 3 ? "OK\r" : "ERROR\r");
         for (int k = 0; k < 3; k++) begin
            {cts_in, tx_drive} = (k == 0) ? 2'h3 : ((k == 1) ? 2'h0 : 2'h1);
            rx_activity = k[0];
            repeat (2) @(negedge clock);
            chk(out2, o2(cs, cts_in, tx_drive));
            chk(rx_ind, (cd == 0) ? rx_activity : (cd == 1));
         end
      end
   endtask : t_lines

   // Channel limits in both modes
   task t_chan;
      hop_mode = 1'h1;
      cmd("ATHP 6\r", "OK\r");
      cmd("ATHP 7\r", "ERROR\r");
      chk(channel, 8'h06);
      hop_mode = 1'h0;
      cmd("ATHP 18\r", "OK\r");
      cmd("ATHP 19\r", "ERROR\r");
      cmd("ATHP\r", "18\r");
   endtask : t_chan

   // Restore, set, save; unsaved change dies
   task t_save;
      cmd("ATRE,DT 1a0d,WR\r", "OK\r");
      cmd("", "OK\r");
      cmd("", "OK\r");
      chk({channel, dest_addr, addr_mask}, 40'h00_1a0d_ffff);
      chk({out2, rx_ind}, {cts_in, rx_activity});
      chk(nv_saved, {mcp_pkg::FACTORY_IMG[55:32], 32'h1a0d_ffff});
      cmd("ATDT 55\r", "OK\r");
      power_up(nv_saved);
      chk(dest_addr, 16'h1a0d);
   endtask : t_save

   // Wake request, clearing, exit
   task t_wake_exit;
      enter();
      cmd("ATFH\r", "OK\r");
      repeat (4) @(negedge clock);
      chk(force_wake, 1'h1);
      wake_sent = 1'h1;
      @(negedge clock);
      wake_sent = 1'h0;
      @(negedge clock);
      chk(force_wake, 1'h0);
      cmd("ATCN\r", "OK\r");
      @(negedge clock);
      chk({cmd_mode, rx_ready}, 2'h0);
   endtask : t_wake_exit

   // Two ticks of silence end command mode
   task t_timeout;
      idle_timeout = 16'h0002;
      enter();
      repeat (2) @(negedge clock);
      chk(cmd_mode, 1'h1);
      repeat (45) @(negedge clock);
      chk(cmd_mode, 1'h0);
   endtask : t_timeout

   // Verdict in one place
   task stop_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // Watchdog, well past the run length
   initial begin
      repeat (30000) @(posedge clock);
      n_errors++;
      stop_test();
   end

   // Main sequence
   initial begin
      rstn = 1'h0;
      cmd_enter = 1'h0;
      idle_timeout = 16'h0040;
      nv_in = 56'h0;
      rssi = 8'h6a;
      hw_version = 16'h3c5a;
      fw_version = 16'h1b07;
      serial_number = 32'h89ab_cdef;
      hop_mode = 1'h1;
      rx_activity = 1'h0;
      cts_in = 1'h0;
      tx_drive = 1'h0;
      wake_sent = 1'h0;
      t_reload();
      t_set();
      t_ro();
      t_lines();
      t_chan();
      t_save();
      t_wake_exit();
      t_timeout();
      stop_test();
   end
endmodule : mcp_top_tb
